// ===== wdt_cfg.svh
/*
  Constants of the window/timeout watchdog: register offsets, field
  positions, reset values and times. Assumes a 50 MHz sys_clk.
*/
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_CLK_HZ       50000000
`define WDT_MS_PER_S     1000
`define WDT_INIT_WIN_MS  15'd150
`define WDT_RST_PULSE_MS 10
`define WDT_ADDR_CFG1    7'h13
`define WDT_ADDR_CFG2    7'h14
`define WDT_ADDR_TRIG    7'h15
`define WDT_ADDR_THR     7'h16
`define WDT_CFG1_RST     8'h40
`define WDT_BIT_TMO      7
`define WDT_BIT_SBY      6
`define WDT_ERR_RST      4'h1
`define WDT_ERR_MAX      4'hF
`define WDT_THR_A        4'h1
`define WDT_THR_B        4'h9
`define WDT_THR_C        4'hF
`define WDT_FRAME_BITS   5'd16
`define WDT_CMD_BITS     5'd8
`endif

// ===== wdt_pkg.sv
/*
  Types of the watchdog: serial pins, device modes, block state and the
  period table in milliseconds. Assumes wdt_cfg.svh for constants.
*/
`default_nettype none
package wdt_pkg;
  typedef struct packed {
    logic csN;
    logic sck;
    logic sdi;
  } wdt_spi_t;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_NORMAL,
    MODE_FAST
  } wdt_mode_t;

  typedef struct packed {
    wdt_spi_t    syn1;
    wdt_spi_t    syn2;
    wdt_spi_t    prev;
    logic        trg1;
    logic        trg2;
    logic        trgPrev;
    logic [15:0] shift;
    logic [4:0]  bitCnt;
    logic [7:0]  txByte;
    logic        sdo;
    logic [7:0]  cfgOne;
    logic [2:0]  timerSel;
    logic [1:0]  thrSel;
    logic [3:0]  errCnt;
    logic        irq;
    logic [15:0] msDiv;
    logic [14:0] msCnt;
    logic        initWin;
    logic        restart;
    logic        faultLow;
    logic [14:0] pulseCnt;
    logic        limp;
    logic        active;
    wdt_mode_t   prevMode;
  } wdt_state_t;

  // Reserved codes run at the longest legal period, never at zero
  localparam logic [14:0] WDT_PERIOD_MS [0:7][0:3] = '{
    '{15'd4,     15'd8,     15'd12,    15'd16},
    '{15'd32,    15'd64,    15'd96,    15'd128},
    '{15'd128,   15'd256,   15'd384,   15'd512},
    '{15'd256,   15'd384,   15'd512,   15'd768},
    '{15'd512,   15'd1024,  15'd1536,  15'd2048},
    '{15'd2048,  15'd4096,  15'd6144,  15'd8192},
    '{15'd10240, 15'd20240, 15'd20240, 15'd20240},
    '{15'd20240, 15'd20240, 15'd20240, 15'd20240}
  };
endpackage : wdt_pkg
`default_nettype wire

// ===== wdt_core.sv
/*
  Window/timeout watchdog with its serial register port, error counter,
  restart pulse and limp-home drive. Assumes the serial pins and the pin
  trigger come from outside the clock domain, and the device mode comes
  from the mode controller on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_core
  import wdt_pkg::*;
#(
  parameter int unsigned MS_CYCLES    = `WDT_CLK_HZ / `WDT_MS_PER_S,
  parameter int unsigned RST_PULSE_MS = `WDT_RST_PULSE_MS
) (
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      reset_n,
  // Serial register port
  input  wire wdt_spi_t  spiIn,
  output logic           spiSdo,
  // Device mode, control method and trigger pin
  input  wire wdt_mode_t opMode,
  input  wire logic      spiControl,
  input  wire logic      pinTrigger,
  // Device outputs
  output logic           systemResetOutLow,
  output logic           watchdogFaultOutLow,
  output logic           interruptRequestLow,
  output logic           limpHomeOn
);
  localparam logic [15:0] MS_LAST    = 16'(MS_CYCLES - 1);
  localparam logic [14:0] PULSE_LAST = 15'(RST_PULSE_MS - 1);
  localparam wdt_state_t ST_RST = '{
    syn1:     '1,
    syn2:     '1,
    prev:     '1,
    cfgOne:   `WDT_CFG1_RST,
    errCnt:   `WDT_ERR_RST,
    prevMode: MODE_SLEEP,
    default:  '0
  };

  wdt_state_t  st;
  wdt_state_t  nxt;
  logic        sckRise;
  logic        sckFall;
  logic        csRise;
  logic        wrEn;
  logic [6:0]  addr;
  logic [6:0]  rdAddr;
  logic [7:0]  data;
  logic        trigger;
  logic        tick;
  logic [14:0] period;
  logic [14:0] limitLast;
  logic        timeoutMode;
  logic        closed;
  logic        expire;
  logic        goodTrig;
  logic        badTrig;
  logic        errEvt;
  logic [3:0]  thr;
  logic [3:0]  incCnt;
  logic        trip;
  logic        cfgWr;
  logic        modeEntry;
  logic        wdRun;
  logic        restartTimer;
  logic [7:0]  rdByte;

  assign sckRise = st.syn2.sck & ~st.prev.sck;
  assign sckFall = ~st.syn2.sck & st.prev.sck;
  assign csRise  = st.syn2.csN & ~st.prev.csN;
  assign wrEn    = csRise && st.bitCnt == `WDT_FRAME_BITS && st.shift[8];
  assign addr    = st.shift[15:9];
  // At the eighth rising edge only the address bits sit in the low end
  assign rdAddr  = st.shift[6:0];
  assign data    = st.shift[7:0];
  // Pin control takes no serial trigger, so the trigger pin stands in
  assign trigger = spiControl ? (wrEn && addr == `WDT_ADDR_TRIG)
                              : (st.trg2 & ~st.trgPrev);
  assign tick    = st.msDiv == MS_LAST;
  assign period  = WDT_PERIOD_MS[st.timerSel][st.cfgOne[5:4]];
  assign limitLast = (st.initWin ? `WDT_INIT_WIN_MS : period) - 15'd1;
  assign timeoutMode = spiControl & st.cfgOne[`WDT_BIT_TMO];
  // Closed half only outside the long window and in window mode
  assign closed  = !timeoutMode && !st.initWin
                   && st.msCnt < {1'b0, period[14:1]};
  assign expire  = st.active && tick && st.msCnt >= limitLast;
  assign badTrig  = st.active && trigger && closed;
  assign goodTrig = st.active && trigger && !closed && !expire;
  assign errEvt  = badTrig | expire;

  always_comb begin
    case (st.thrSel)
      2'b01:   thr = `WDT_THR_B;
      2'b10:   thr = `WDT_THR_C;
      default: thr = `WDT_THR_A;
    endcase
  end

  assign incCnt = (st.errCnt == `WDT_ERR_MAX) ? `WDT_ERR_MAX
                                              : st.errCnt + 4'h1;
  assign trip   = spiControl && errEvt && incCnt >= thr;
  assign cfgWr  = wrEn && st.active && (
                  (addr == `WDT_ADDR_CFG1 && data != st.cfgOne) ||
                  (addr == `WDT_ADDR_CFG2 && data[7:5] != st.timerSel) ||
                  (addr == `WDT_ADDR_THR && data[7:6] != st.thrSel));
  assign modeEntry = opMode != st.prevMode && opMode != MODE_SLEEP;
  assign wdRun  = !st.restart && (opMode == MODE_NORMAL
                  || opMode == MODE_FAST || (opMode == MODE_STANDBY
                  && st.cfgOne[`WDT_BIT_SBY]));
  assign restartTimer = errEvt | goodTrig | cfgWr | modeEntry;

  always_comb begin
    if (rdAddr == `WDT_ADDR_CFG1) begin
      rdByte = st.cfgOne;
    end else if (rdAddr == `WDT_ADDR_CFG2) begin
      rdByte = {st.timerSel, st.errCnt, st.irq};
    end else if (rdAddr == `WDT_ADDR_THR) begin
      rdByte = {st.thrSel, 6'h00};
    end else begin
      rdByte = 8'h00;
    end
  end

  always_comb begin
    nxt = st;
    nxt.syn1 = spiIn;
    nxt.syn2 = st.syn1;
    nxt.prev = st.syn2;
    nxt.trg1 = pinTrigger;
    nxt.trg2 = st.trg1;
    nxt.trgPrev = st.trg2;
    nxt.prevMode = opMode;
    nxt.active = wdRun;
    // Serial frame: address and write bit, then one data byte
    if (st.syn2.csN) begin
      nxt.bitCnt = 5'd0;
      nxt.sdo = 1'b0;
    end else if (sckRise) begin
      nxt.shift = {st.shift[14:0], st.syn2.sdi};
      if (st.bitCnt != `WDT_FRAME_BITS) begin
        nxt.bitCnt = st.bitCnt + 5'd1;
      end
      if (st.bitCnt == `WDT_CMD_BITS - 5'd1) begin
        nxt.txByte = rdByte;
      end
    end else if (sckFall && st.bitCnt >= `WDT_CMD_BITS) begin
      nxt.sdo = st.txByte[7];
      nxt.txByte = {st.txByte[6:0], 1'b0};
    end
    if (wrEn) begin
      if (addr == `WDT_ADDR_CFG1) begin
        nxt.cfgOne = data;
      end else if (addr == `WDT_ADDR_CFG2) begin
        nxt.timerSel = data[7:5];
        if (data[0]) begin
          nxt.irq = 1'b0;
        end
      end else if (addr == `WDT_ADDR_THR) begin
        nxt.thrSel = data[7:6];
      end
    end
    // Set after the clear so a coincident bad trigger is kept
    if (badTrig) begin
      nxt.irq = 1'b1;
    end
    // Period timer in millisecond ticks
    nxt.msDiv = tick ? 16'h0000 : st.msDiv + 16'h0001;
    if (tick) begin
      nxt.msCnt = st.msCnt + 15'd1;
    end
    // Divider keeps running during a pulse so the pulse can time out
    if (restartTimer || (!st.active && !st.restart && !st.faultLow)) begin
      nxt.msDiv = 16'h0000;
    end
    if (restartTimer || !st.active) begin
      nxt.msCnt = 15'd0;
    end
    if (goodTrig || expire) begin
      nxt.initWin = 1'b0;
    end
    if (modeEntry && ((opMode == MODE_NORMAL
        && !st.cfgOne[`WDT_BIT_SBY]) || (opMode == MODE_STANDBY
        && st.cfgOne[`WDT_BIT_SBY]))) begin
      nxt.initWin = 1'b1;
    end
    // Error counter
    if (cfgWr) begin
      nxt.errCnt = `WDT_ERR_RST;
    end else if (trip) begin
      nxt.errCnt = `WDT_ERR_RST;
    end else if (errEvt) begin
      nxt.errCnt = incCnt;
    end else if (goodTrig && st.errCnt != 4'h0) begin
      nxt.errCnt = st.errCnt - 4'h1;
    end
    // Reset pulse and pin-control fault pulse share one counter
    if (trip) begin
      nxt.restart = 1'b1;
      nxt.pulseCnt = 15'd0;
    end else if (!spiControl && errEvt) begin
      nxt.faultLow = 1'b1;
      nxt.pulseCnt = 15'd0;
    end else if ((st.restart || st.faultLow) && tick) begin
      if (st.pulseCnt == PULSE_LAST) begin
        nxt.restart = 1'b0;
        nxt.faultLow = 1'b0;
        nxt.initWin = st.restart;
      end else begin
        nxt.pulseCnt = st.pulseCnt + 15'd1;
      end
    end
    if (opMode == MODE_SLEEP) begin
      nxt.limp = 1'b0;
    end else if (trip) begin
      nxt.limp = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= ST_RST;
    end else begin
      st <= nxt;
    end
  end

  assign spiSdo              = st.sdo;
  assign systemResetOutLow   = ~st.restart;
  assign watchdogFaultOutLow = ~st.faultLow;
  assign interruptRequestLow = ~st.irq;
  assign limpHomeOn          = st.limp;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_trip;
    trip;
  endsequence
  sequence s_hold_low;
    !systemResetOutLow [*8];
  endsequence

  a_trip_pulse: assert property (s_trip |=> s_hold_low)
    else $error("reset pulse too short after trip");
  a_rise_long_win: assert property ($rose(systemResetOutLow)
    |-> st.initWin)
    else $error("no long window after reset release");
  a_good_decr: assert property (goodTrig && !cfgWr && st.errCnt != 4'h0
    |=> st.errCnt == $past(st.errCnt) - 4'h1)
    else $error("good trigger did not decrement");
  a_floor_zero: assert property (goodTrig && !cfgWr
    && st.errCnt == 4'h0 |=> st.errCnt == 4'h0)
    else $error("error count went below zero");
  a_closed_irq: assert property (st.active && trigger && !timeoutMode
    && !st.initWin && st.msCnt < {1'b0, period[14:1]}
    |=> !interruptRequestLow)
    else $error("closed window trigger not flagged");
  a_timeout_ok: assert property (st.active && trigger && timeoutMode
    && !expire |=> $stable(interruptRequestLow))
    else $error("timeout trigger flagged as error");
  a_cfg_change: assert property (cfgWr |=> st.errCnt == `WDT_ERR_RST
    && st.msCnt == 15'd0)
    else $error("config change did not reset counter");
  a_limp_sleep: assert property (opMode == MODE_SLEEP
    |=> !limpHomeOn)
    else $error("limp home on in sleep");
  a_pin_fault: assert property (!spiControl && errEvt
    |=> !watchdogFaultOutLow)
    else $error("fault pin not low on error");
  a_mode_entry: assert property (modeEntry |=> st.msCnt == 15'd0)
    else $error("mode entry did not restart timer");
endmodule : wdt_core
`default_nettype wire

// ===== wdt_host_model.sv
/*
  Host processor model: drives 16-bit serial frames into the watchdog.
  Assumes sys_clk from the bench; sck half period is 6 sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_host_model
  import wdt_pkg::*;
(
  // Clock
  input  wire logic    sys_clk,
  // Serial pins
  output var wdt_spi_t spiOut,
  input  wire logic    spiSdo
);
  localparam int HALF = 6;

  // Deselected data line rests at its pull-up level
  initial spiOut = '{csN: 1'b1, sck: 1'b0, sdi: 1'b1};

  task automatic waitClk(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : waitClk

  // Trigger is a write frame to the trigger register
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {cmd, wd};
    rdat = 8'h00;
    waitClk(1);
    spiOut.csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spiOut.sdi = frame[i];
      waitClk(HALF);
      if (i < 8) begin
        rdat = {rdat[6:0], spiSdo};
      end
      spiOut.sck = 1'b1;
      waitClk(HALF);
      spiOut.sck = 1'b0;
    end
    waitClk(HALF);
    spiOut.csN = 1'b1;
    spiOut.sdi = 1'b1;
    waitClk(HALF);
  endtask : xfer
endmodule : wdt_host_model
`default_nettype wire

// ===== wdt_tb.sv
/*
  Self-checking bench of wdt_core. Assumes wdt_host_model for frames;
  1 ms is shortened to 4 sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module tb
  import wdt_pkg::*;
;
  localparam int MS_CYC   = 4;
  localparam int PULSE_MS = 10;
  logic       sys_clk    = 1'b0;
  logic       reset_n    = 1'b0;
  wdt_mode_t  opMode     = MODE_SLEEP;
  logic       spiControl = 1'b1;
  logic       pinTrigger = 1'b0;
  wdt_spi_t   spiIn;
  logic       spiSdo;
  logic       rstLow;
  logic       faultLow;
  logic       irqLow;
  logic       limpOn;
  logic [7:0] rdv;
  int         n;
  int         cyc        = 0;
  int         lowCyc     = 0;
  int         failCount  = 0;
  int         nCompared  = 0;

  wdt_core #(.MS_CYCLES(MS_CYC), .RST_PULSE_MS(PULSE_MS)) wdt_core_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .spiIn(spiIn),
    .spiSdo(spiSdo), .opMode(opMode), .spiControl(spiControl),
    .pinTrigger(pinTrigger), .systemResetOutLow(rstLow),
    .watchdogFaultOutLow(faultLow), .interruptRequestLow(irqLow),
    .limpHomeOn(limpOn));
  wdt_host_model wdt_host_model_inst (
    .sys_clk(sys_clk), .spiOut(spiIn), .spiSdo(spiSdo));

  always #10 sys_clk = ~sys_clk;

  // Length in cycles of the reset pulse now low, or for one cycle after it ends
  always @(posedge sys_clk) begin
    lowCyc <= rstLow ? 0 : lowCyc + 1;
  end

  // Whole run needs about 4100 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      failCount = failCount + 1;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    $display("Compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : giveVerdict

  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] g);
    nCompared++;
    if (g !== e) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic clk(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : clk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    wdt_host_model_inst.xfer({a, 1'b1}, d, unused);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    wdt_host_model_inst.xfer({a, 1'b0}, 8'h00, d);
  endtask : rd

  task automatic testReset();
    check("limp", 8'h00, {7'h00, limpOn});
    rd(`WDT_ADDR_CFG1, rdv);
    check("cfgOne", `WDT_CFG1_RST, rdv);
    rd(`WDT_ADDR_CFG2, rdv);
    check("cfgTwo", 8'h02, rdv);
    rd(7'h20, rdv);
    check("unmapped", 8'h00, rdv);
    $display("reset test done");
  endtask : testReset

  // Period 128 ms: early trigger lands in the closed half
  task automatic testTrip();
    wr(`WDT_ADDR_CFG2, 8'h20);
    wr(`WDT_ADDR_CFG1, 8'h70);
    opMode = MODE_NORMAL;
    wr(`WDT_ADDR_TRIG, 8'h00);
    n = 0;
    while (rstLow !== 1'b0 && n < 20) begin
      clk(1);
      n++;
    end
    check("irqOut", 8'h00, {7'h00, irqLow});
    check("limp", 8'h01, {7'h00, limpOn});
    n = 0;
    while (rstLow === 1'b0 && n < 100) begin
      clk(1);
      n++;
    end
    // Pulse is whole ms ticks, with up to one ms of divider phase
    check("pulseOk", 8'h01, {7'h00, lowCyc >= PULSE_MS * MS_CYC
          && lowCyc <= (PULSE_MS + 1) * MS_CYC});
    $display("trip test done");
  endtask : testTrip

  task automatic testLongWin();
    wr(`WDT_ADDR_TRIG, 8'h00);
    wr(`WDT_ADDR_CFG2, 8'h21);
    // Lands near 80% of 128 ms: open even with 10% oscillator error
    wr(`WDT_ADDR_TRIG, 8'h00);
    check("irqOut", 8'h01, {7'h00, irqLow});
    rd(`WDT_ADDR_CFG2, rdv);
    check("cfgTwo", 8'h20, rdv);
    opMode = MODE_SLEEP;
    clk(3);
    check("limp", 8'h00, {7'h00, limpOn});
    $display("long window test done");
  endtask : testLongWin

  // Triggers right after entry would be early in window mode
  task automatic testTimeout();
    wr(`WDT_ADDR_CFG1, 8'hF0);
    wr(`WDT_ADDR_THR, 8'h40);
    opMode = MODE_NORMAL;
    wr(`WDT_ADDR_TRIG, 8'h00);
    wr(`WDT_ADDR_TRIG, 8'h00);
    rd(`WDT_ADDR_CFG2, rdv);
    check("cfgTwo", 8'h20, rdv);
    wr(`WDT_ADDR_THR, 8'h80);
    rd(`WDT_ADDR_CFG2, rdv);
    check("cfgTwo", 8'h22, rdv);
    rd(`WDT_ADDR_THR, rdv);
    check("thr", 8'h80, rdv);
    clk(150);
    rd(`WDT_ADDR_CFG2, rdv);
    check("cfgTwo", 8'h24, rdv);
    check("irqOut", 8'h01, {7'h00, irqLow});
    $display("timeout test done");
  endtask : testTimeout

  task automatic testPin();
    opMode = MODE_SLEEP;
    spiControl = 1'b0;
    clk(2);
    opMode = MODE_NORMAL;
    clk(20);
    pinTrigger = 1'b1;
    n = 0;
    while (faultLow !== 1'b0 && n < 10) begin
      clk(1);
      n++;
    end
    check("faultOut", 8'h00, {7'h00, faultLow});
    pinTrigger = 1'b0;
    $display("pin test done");
  endtask : testPin

  initial begin
    clk(4);
    reset_n = 1'b1;
    clk(3);
    testReset();
    testTrip();
    testLongWin();
    testTimeout();
    testPin();
    giveVerdict();
  end
endmodule : tb
`default_nettype wire
